// ### common/iarc_pkg.sv
// iarc_pkg: register indices, field positions, reset values, timing
// counts and carrier types for the interrupt and converter run control.
// assumes a word-per-register slave: byte address = 4 * register index.
package iarc_pkg;

    // ======================================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_KEY_MASK = 8'he8;
    localparam logic [7:0] IDX_TICK_MASK = 8'heb;
    localparam logic [7:0] IDX_CONV_MASK = 8'hec;
    localparam logic [7:0] IDX_KEY_FLAG = 8'hed;
    localparam logic [7:0] IDX_TICK_FLAG = 8'hef;
    localparam logic [7:0] IDX_CONV_FLAG = 8'hf0;
    localparam logic [7:0] IDX_CONV_CTRL = 8'hf1;
    localparam logic [7:0] IDX_CORE_CTRL = 8'he0;
    localparam logic [7:0] IDX_CORE_STAT = 8'he1;

    // ======================================================================
    // field positions
    localparam int RUN_BIT = 0;
    localparam int CHSEL_BIT = 3;
    localparam int GIE_BIT = 0;
    localparam int STAT_HALT_BIT = 0;
    localparam int STAT_VEC_BIT = 1;
    localparam int STAT_REQ_BIT = 2;
    localparam int STAT_RUN_BIT = 3;
    localparam int TICK_2HZ_BIT = 2;
    localparam int TICK_8HZ_BIT = 1;
    localparam int TICK_32HZ_BIT = 0;

    // ======================================================================
    // reset values and bus answers
    localparam logic [3:0] NIBBLE_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int MAP_ADDR_BITS = 10;

    // ======================================================================
    // timing: pc save plus vector load, in core clock cycles
    localparam logic [3:0] VEC_CYCLES = 4'hc;

    // ======================================================================
    // carriers and states
    typedef struct packed {
        logic count_zero; // up/down count reached zero: conversion over
        logic overflow;   // up/down count overflowed
        logic meas_done;  // measurement finished
    } iarc_conv_evt_s;

    typedef struct packed {
        logic hz2;
        logic hz8;
        logic hz32;
    } iarc_tick_s;

    typedef enum logic [1:0] {
        VS_IDLE = 2'h0,
        VS_SAVE = 2'h1,
        VS_LOAD = 2'h3
    } iarc_vec_e;

endpackage

// ### verilog/iarc_flag_bank.sv
// iarc_flag_bank: a group of interrupt factor flags cleared on read.
// assumes set pulses and the read strobe are synchronous to aclk.
`timescale 1ns/1ps

module iarc_flag_bank import iarc_pkg::*; #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // events and read strobe
    input wire logic [W-1:0] set,
    input wire logic rd_clr,
    // flag state
    output logic [W-1:0] flags
);

    // ======================================================================
    // elaboration check
    if (W < 1 || W > 4) begin : g_bad_w
        $error("iarc_flag_bank: W must be 1 to 4");
    end

    logic [W-1:0] flags_q;
    logic [W-1:0] flags_d;

    // set beats the read clear so an edge landing on the read is kept
    always_comb begin
        flags_d = (flags_q & ~{W{rd_clr}}) | set; // see [R09] see [R20]
    end

    // initial reset drops every flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= '0; // see [R14]
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule

// ### verilog/iarc_ctrl.sv
// iarc_ctrl: interrupt control and converter run control, AXI4-Lite slave.
// assumes tick, key and converter event inputs are synchronous to aclk.
//
// Operation
// [R01] writing one to the run bit starts a conversion; run bit reads back
// [R02] run bit stays one during conversion, hardware clears it at the end
// [R03] writing zero while converting pauses instead of completing
// [R04] run bit cleared by reset, counter overflow, and measurement done
// [R05] channel select picks second sensor when one, readable, resets zero
// [R06] software sets channel select before setting the run bit
// [R07] converter mask bit enables its interrupt, readable, resets zero
// [R08] converter flag sets when the up/down count reaches zero
// [R09] factor flags are read-only and cleared by a read
// [R10] request only when flag, its mask and global enable are all one
// [R11] accepting an interrupt clears the global enable
// [R12] halt stops the core clock; any request restarts it
// [R13] falling tick edges at 2, 8, 32 Hz set the three tick flags
// [R14] initial reset clears all factor flags
// [R15] software takes care reading flags while interrupts are enabled
// [R16] four key pins each have a mask, sharing one edge flag
// [R17] three tick mask bits, enable when one, reset to zero
// [R18] pc save and vector load take twelve core clock cycles
// [R19] unused nibble bits read zero and ignore writes
// [R20] flags set regardless of mask; mask only gates the request
`timescale 1ns/1ps

module iarc_ctrl import iarc_pkg::*; #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt sources
    input wire iarc_tick_s ticks,
    input wire logic [3:0] key_inputs,
    input wire iarc_conv_evt_s conv_evt,
    // converter control
    output logic conv_run,
    output logic conv_start,
    output logic conv_pause,
    output logic sensor_channel_sel,
    // cpu core side
    input wire logic irq_ack,
    input wire logic halt_req,
    output logic irq_req,
    output logic core_clk_en,
    output logic vec_busy,
    output logic vec_load
);

    // ======================================================================
    // elaboration check
    if (ADDR_W < MAP_ADDR_BITS || ADDR_W > 32) begin : g_bad_addr
        $error("iarc_ctrl: ADDR_W must be 10 to 32");
    end

    // decode: upper bits zero and word index match
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        return ((a >> MAP_ADDR_BITS) == '0) && (a[9:2] == idx);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return hit(a, IDX_KEY_MASK) || hit(a, IDX_TICK_MASK) ||
               hit(a, IDX_CONV_MASK) || hit(a, IDX_KEY_FLAG) ||
               hit(a, IDX_TICK_FLAG) || hit(a, IDX_CONV_FLAG) ||
               hit(a, IDX_CONV_CTRL) || hit(a, IDX_CORE_CTRL) ||
               hit(a, IDX_CORE_STAT);
    endfunction

    // ======================================================================
    // declarations
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [3:0] wdata_q, wdata_d;
    logic wlane_q, wlane_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [3:0] rdata_q, rdata_d;
    logic wr_fire, ar_fire;
    logic [3:0] key_mask_q, key_mask_d;
    logic [2:0] tick_mask_q, tick_mask_d;
    logic conv_mask_q, conv_mask_d;
    logic run_q, run_d, chsel_q, chsel_d;
    logic start_q, start_d, pause_q, pause_d;
    logic global_q, global_d, halt_q, halt_d;
    logic [2:0] tick_now, tick_prev_q, tick_fall;
    logic [3:0] key_prev_q, key_rise, key_src_q, key_src_d;
    logic [2:0] tick_flag;
    logic key_flag, conv_flag;
    logic clr_tick, clr_key, clr_conv;
    logic conv_stop;
    iarc_vec_e vs_q, vs_d;
    logic [3:0] vcnt_q, vcnt_d;

    // ======================================================================
    // axi handshakes: address and data taken in either order
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = {28'h0000000, rdata_q};

    // read side effect: a flag read clears that flag group
    assign clr_tick = ar_fire && hit(s_axi_araddr, IDX_TICK_FLAG); // see [R09]
    assign clr_key = ar_fire && hit(s_axi_araddr, IDX_KEY_FLAG);
    assign clr_conv = ar_fire && hit(s_axi_araddr, IDX_CONV_FLAG);

    // bus next state
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        wdata_d = wdata_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata[3:0];
            wlane_d = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (ar_fire) begin
            rvalid_d = 1'b1;
            rresp_d = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            // unused bits come back zero
            rdata_d = 4'h0; // see [R19]
            if (hit(s_axi_araddr, IDX_KEY_MASK)) begin
                rdata_d = key_mask_q;
            end
            if (hit(s_axi_araddr, IDX_TICK_MASK)) begin
                rdata_d = {1'b0, tick_mask_q}; // see [R17]
            end
            if (hit(s_axi_araddr, IDX_CONV_MASK)) begin
                rdata_d = {3'h0, conv_mask_q}; // see [R07]
            end
            if (hit(s_axi_araddr, IDX_KEY_FLAG)) begin
                rdata_d = {3'h0, key_flag};
            end
            if (hit(s_axi_araddr, IDX_TICK_FLAG)) begin
                rdata_d = {1'b0, tick_flag};
            end
            if (hit(s_axi_araddr, IDX_CONV_FLAG)) begin
                rdata_d = {3'h0, conv_flag};
            end
            if (hit(s_axi_araddr, IDX_CONV_CTRL)) begin
                rdata_d = {chsel_q, 2'h0, run_q}; // see [R01] see [R05]
            end
            if (hit(s_axi_araddr, IDX_CORE_CTRL)) begin
                rdata_d = {3'h0, global_q};
            end
            if (hit(s_axi_araddr, IDX_CORE_STAT)) begin
                rdata_d = {run_q, irq_req, vec_busy, halt_q};
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q <= 1'b0;
            wdata_q <= 4'h0;
            wlane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 4'h0;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            wdata_q <= wdata_d;
            wlane_q <= wlane_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // ======================================================================
    // event edges: inputs already synchronous, one stage of history
    assign tick_now = {ticks.hz2, ticks.hz8, ticks.hz32};
    assign tick_fall = tick_prev_q & ~tick_now; // see [R13]
    assign key_rise = key_inputs & ~key_prev_q;
    // key pins remembered so each pin's own mask can gate the shared flag
    assign key_src_d = (key_src_q & ~{4{clr_key}}) | key_rise; // see [R16]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_prev_q <= 3'h0;
            key_prev_q <= 4'h0;
            key_src_q <= 4'h0;
        end else begin
            tick_prev_q <= tick_now;
            key_prev_q <= key_inputs;
            key_src_q <= key_src_d;
        end
    end

    // ======================================================================
    // factor flags: set whatever the masks say
    iarc_flag_bank #(.W(3)) u_tick_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(tick_fall),
        .rd_clr(clr_tick),
        .flags(tick_flag)
    );

    iarc_flag_bank #(.W(1)) u_key_flag (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(|key_rise),
        .rd_clr(clr_key),
        .flags(key_flag)
    );

    iarc_flag_bank #(.W(1)) u_conv_flag (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(conv_evt.count_zero), // see [R08] see [R20]
        .rd_clr(clr_conv),
        .flags(conv_flag)
    );

    // request needs flag, mask and global enable together
    assign irq_req = global_q && (|(tick_flag & tick_mask_q) ||
                     (conv_flag && conv_mask_q) ||
                     (key_flag && |(key_src_q & key_mask_q))); // see [R10]

    // ======================================================================
    // control registers, converter run and core state
    assign conv_stop = conv_evt.count_zero || conv_evt.overflow ||
                       conv_evt.meas_done;

    always_comb begin
        key_mask_d = key_mask_q;
        tick_mask_d = tick_mask_q;
        conv_mask_d = conv_mask_q;
        run_d = run_q;
        chsel_d = chsel_q;
        global_d = global_q;
        halt_d = halt_q;
        start_d = 1'b0;
        pause_d = 1'b0;
        // only byte lane 0 carries the nibble; other bits dropped
        if (wr_fire && wlane_q) begin // see [R19]
            if (hit(aw_addr_q, IDX_KEY_MASK)) begin
                key_mask_d = wdata_q; // see [R16]
            end
            if (hit(aw_addr_q, IDX_TICK_MASK)) begin
                tick_mask_d = wdata_q[2:0]; // see [R17]
            end
            if (hit(aw_addr_q, IDX_CONV_MASK)) begin
                conv_mask_d = wdata_q[0]; // see [R07]
            end
            if (hit(aw_addr_q, IDX_CORE_CTRL)) begin
                global_d = wdata_q[GIE_BIT];
            end
            if (hit(aw_addr_q, IDX_CONV_CTRL)) begin
                chsel_d = wdata_q[CHSEL_BIT]; // see [R05]
                if (wdata_q[RUN_BIT]) begin
                    run_d = 1'b1; // see [R01]
                    start_d = !run_q;
                end else if (run_q) begin
                    run_d = 1'b0; // see [R03]
                    pause_d = 1'b1;
                end
            end
        end
        // hardware stop wins over a software start in the same cycle
        if (conv_stop) begin
            run_d = 1'b0; // see [R02] see [R04]
            start_d = 1'b0;
            pause_d = 1'b0;
        end
        if (irq_ack) begin
            global_d = 1'b0; // see [R11]
        end
        // a pending request stops a halt from sticking
        if (halt_req) begin
            halt_d = 1'b1;
        end
        if (irq_req) begin
            halt_d = 1'b0; // see [R12]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_mask_q <= NIBBLE_RST;
            tick_mask_q <= NIBBLE_RST[2:0];
            conv_mask_q <= NIBBLE_RST[0];
            run_q <= NIBBLE_RST[RUN_BIT]; // see [R04]
            chsel_q <= NIBBLE_RST[CHSEL_BIT];
            global_q <= 1'b0;
            halt_q <= 1'b0;
            start_q <= 1'b0;
            pause_q <= 1'b0;
        end else begin
            key_mask_q <= key_mask_d;
            tick_mask_q <= tick_mask_d;
            conv_mask_q <= conv_mask_d;
            run_q <= run_d;
            chsel_q <= chsel_d;
            global_q <= global_d;
            halt_q <= halt_d;
            start_q <= start_d;
            pause_q <= pause_d;
        end
    end

    assign conv_run = run_q;
    assign conv_start = start_q;
    assign conv_pause = pause_q;
    assign sensor_channel_sel = chsel_q;
    assign core_clk_en = !halt_q;

    // ======================================================================
    // vector sequence: twelve cycles from accept, last one loads the vector
    always_comb begin
        vs_d = vs_q;
        vcnt_d = vcnt_q;
        unique case (vs_q)
            VS_IDLE: begin
                if (irq_ack) begin
                    vs_d = VS_SAVE;
                    vcnt_d = 4'h1;
                end
            end
            VS_SAVE: begin
                vcnt_d = vcnt_q + 4'h1;
                if (vcnt_q == VEC_CYCLES - 4'h1) begin
                    vs_d = VS_LOAD; // see [R18]
                end
            end
            VS_LOAD: begin
                vs_d = VS_IDLE;
            end
            default: begin
                vs_d = VS_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vs_q <= VS_IDLE;
            vcnt_q <= 4'h0;
        end else begin
            vs_q <= vs_d;
            vcnt_q <= vcnt_d;
        end
    end

    assign vec_busy = (vs_q != VS_IDLE);
    assign vec_load = (vs_q == VS_LOAD);

    // ======================================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic run_wr, stop_wr;
    assign run_wr = wr_fire && wlane_q && hit(aw_addr_q, IDX_CONV_CTRL) &&
                    wdata_q[RUN_BIT];
    assign stop_wr = wr_fire && wlane_q && hit(aw_addr_q, IDX_CONV_CTRL) &&
                     !wdata_q[RUN_BIT];

    AST_RUN_START: assert property (run_wr && !conv_stop |=> conv_run) // [R01]
        else $error("run bit not set by write");
    AST_RUN_END: assert property (conv_evt.count_zero |=> !conv_run) // [R02]
        else $error("run bit not cleared at conversion end");
    AST_PAUSE: assert property (stop_wr && conv_run && !conv_stop
        |=> conv_pause && !conv_run) // [R03]
        else $error("zero write did not pause");
    AST_STOP: assert property (conv_evt.overflow || conv_evt.meas_done
        |=> !conv_run && !conv_start) // [R04]
        else $error("run bit survived overflow or done");
    AST_CHSEL: assert property (!wr_fire |=> $stable(sensor_channel_sel))
        // [R05]
        else $error("channel select moved without write");
    AST_CONV_FLAG: assert property (conv_evt.count_zero |=> conv_flag) // [R08]
        else $error("converter flag not set");
    AST_RDCLR: assert property (clr_conv && !conv_evt.count_zero
        |=> !conv_flag) // [R09]
        else $error("flag not cleared by read");
    AST_GATE: assert property (irq_req |-> global_q &&
        (|tick_mask_q || conv_mask_q || |key_mask_q)) // [R10]
        else $error("request without enable");
    AST_ACK: assert property (irq_ack |=> !global_q) // [R11]
        else $error("global enable kept after accept");
    AST_WAKE: assert property (halt_q && irq_req |=> core_clk_en) // [R12]
        else $error("halt not left on request");
    AST_VEC: assert property ($rose(vec_busy)
        |-> !vec_load [*8] ##4 vec_load ##1 !vec_busy) // [R18]
        else $error("vector sequence length wrong");
    AST_TICK: assert property ($fell(ticks.hz2)
        |=> tick_flag[TICK_2HZ_BIT]) // [R13]
        else $error("2 Hz tick flag not set");

    COV_CONV_IRQ: cover property (conv_evt.count_zero ##1 irq_req ##[1:5]
        irq_ack);
    COV_HALT_WAKE: cover property (halt_q ##1 irq_req ##1 core_clk_en);
    COV_PAUSE: cover property (conv_run ##1 conv_pause);

endmodule

// ### verif/iarc_core_model.sv
// iarc_core_model: behavioural cpu core that answers the interrupt block.
// assumes requests, halts and the bench's commands sit in the aclk domain.
`timescale 1ns/1ps

module iarc_core_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request from the block, ack delay and halt command from the bench
    input wire logic irq_req,
    input wire logic [3:0] dly,
    input wire logic hlt,
    // answers to the block
    output logic irq_ack,
    output logic halt_req
);
    logic [3:0] wait_q;

    // one ack per request after dly cycles; a slow core leaves it pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_q <= 4'h0;
            irq_ack <= 1'h0;
            halt_req <= 1'h0;
        end else begin
            halt_req <= hlt;
            irq_ack <= irq_req && !irq_ack && wait_q == dly;
            wait_q <= (irq_req && !irq_ack) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule

// ### verif/testbench.sv
// testbench: axi4-lite master, event drivers and queued result checks.
// assumes the core model acks requests by itself after dly cycles.
`timescale 1ns/1ps

module testbench import iarc_pkg::*; ;
    logic aclk = '0, aresetn = '0, awv = '0, wv = '0, bre = '0;
    logic arv = '0, rre = '0, hlt = '0, ack, hreq;
    logic awr, wr, bv, arr, rv, run, st, pz, chs, irq, cken, vb, vl;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd;
    logic [3:0] ws = '0, keys = '0, rnd;
    logic [1:0] brs, rrs;
    iarc_tick_s tk = '0;
    iarc_conv_evt_s ev = '0;
    int failures = 0, checks_done = 0, cyc = 0, vcnt = 0;
    int nst = 0, npz = 0;
    logic [33:0] q[$];

    always #5 aclk = ~aclk;

    iarc_ctrl #(.ADDR_W(12)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(brs), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rrs),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .ticks(tk),
        .key_inputs(keys), .conv_evt(ev), .conv_run(run),
        .conv_start(st), .conv_pause(pz), .sensor_channel_sel(chs),
        .irq_ack(ack), .halt_req(hreq), .irq_req(irq),
        .core_clk_en(cken), .vec_busy(vb), .vec_load(vl));
    iarc_core_model core_u (.aclk(aclk), .aresetn(aresetn),
        .irq_req(irq), .dly(4'h3), .hlt(hlt), .irq_ack(ack),
        .halt_req(hreq));

    // =======================================================================
    // checking and closing
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // answers are compared mid-cycle, where they are settled
    always @(negedge aclk) begin
        if (bv & bre) check({brs, 32'h0}, q.pop_front());
        if (rv & rre) check({rrs, rd}, q.pop_front());
        vcnt = vb ? vcnt + 1 : 0;
        // start and pause are one-cycle pulses: count them as they stand
        nst += st;
        npz += pz;
        if (vl) check(34'(vcnt), 34'd12);
    end

    // a hang is cut short well past the expected run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end

    // =======================================================================
    // bus and event drivers
    task automatic wreg(input logic [7:0] i, input logic [3:0] d,
                        input logic [1:0] r);
        logic a, w;
        q.push_back({r, 32'h0});
        @(posedge aclk);
        awa <= {2'h0, i, 2'h0};
        wd <= {28'($urandom()), d};
        ws <= 4'hf;
        awv <= 1'h1;
        wv <= 1'h1;
        bre <= 1'h1;
        do begin
            @(negedge aclk);
            a = awr & awv;
            w = wr & wv;
            @(posedge aclk);
            if (a) awv <= 1'h0;
            if (w) wv <= 1'h0;
        end while (awv | wv);
        do @(negedge aclk); while (!bv);
        @(posedge aclk);
        bre <= 1'h0;
    endtask

    task automatic rreg(input logic [7:0] i, input logic [3:0] d,
                        input logic [1:0] r);
        q.push_back({r, 28'h0, d});
        @(posedge aclk);
        ara <= {2'h0, i, 2'h0};
        arv <= 1'h1;
        rre <= 1'h1;
        do @(negedge aclk); while (!arr);
        @(posedge aclk);
        arv <= 1'h0;
        do @(negedge aclk); while (!rv);
        @(posedge aclk);
        rre <= 1'h0;
    endtask

    task automatic evt(input iarc_conv_evt_s v);
        @(posedge aclk);
        ev <= v;
        @(posedge aclk);
        ev <= '0;
    endtask

    // =======================================================================
    // main sequence
    initial begin
        void'($urandom(32'h2a796cfe));
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rreg(IDX_CONV_MASK, 4'h0, RESP_OKAY);
        rreg(IDX_CONV_CTRL, 4'h0, RESP_OKAY);
        rreg(IDX_TICK_MASK, 4'h0, RESP_OKAY);
        rreg(IDX_CONV_FLAG, 4'h0, RESP_OKAY);
        // channel first, then run with upper bits set
        wreg(IDX_CONV_CTRL, 4'h8, RESP_OKAY);
        wreg(IDX_CONV_CTRL, 4'hf, RESP_OKAY);
        @(negedge aclk);
        check({chs, run}, 34'h3);
        rreg(IDX_CONV_CTRL, 4'h9, RESP_OKAY);
        wreg(IDX_CONV_CTRL, 4'h8, RESP_OKAY);
        rreg(IDX_CONV_CTRL, 4'h8, RESP_OKAY);
        rreg(IDX_CONV_FLAG, 4'h0, RESP_OKAY);
        // each hardware stop cause, only count_zero marks completion
        for (int k = 0; k < 3; k++) begin
            wreg(IDX_CONV_CTRL, 4'h1, RESP_OKAY);
            evt(3'h1 << k);
            rreg(IDX_CONV_CTRL, 4'h0, RESP_OKAY);
            rreg(IDX_CONV_FLAG, {3'h0, k == 2}, RESP_OKAY);
        end
        rreg(IDX_CONV_FLAG, 4'h0, RESP_OKAY);
        wreg(IDX_CONV_FLAG, 4'h1, RESP_OKAY);
        rreg(IDX_CONV_FLAG, 4'h0, RESP_OKAY);
        wreg(8'h10, 4'h5, RESP_SLVERR);
        rreg(8'h10, 4'h0, RESP_SLVERR);
        // global on, masks off: flag reads cannot race a request
        wreg(IDX_CORE_CTRL, 4'h1, RESP_OKAY);
        for (int k = 0; k < 3; k++) begin
            @(posedge aclk);
            tk <= 3'h1 << k;
            @(posedge aclk);
            tk <= '0;
            repeat (2) @(negedge aclk);
            check(irq, 34'h0);
            rreg(IDX_TICK_FLAG, 4'(1 << k), RESP_OKAY);
        end
        rnd = 4'($urandom());
        wreg(IDX_TICK_MASK, rnd, RESP_OKAY);
        rreg(IDX_TICK_MASK, rnd & 4'h7, RESP_OKAY);
        wreg(IDX_KEY_MASK, 4'h4, RESP_OKAY);
        @(posedge aclk);
        keys <= 4'h1;
        repeat (2) @(negedge aclk);
        check(irq, 34'h0);
        rreg(IDX_KEY_FLAG, 4'h1, RESP_OKAY);
        // halt, then a converter request wakes the core and is taken
        wreg(IDX_CONV_MASK, 4'h1, RESP_OKAY);
        @(posedge aclk);
        hlt <= 1'h1;
        @(posedge aclk);
        hlt <= 1'h0;
        repeat (3) @(negedge aclk);
        check(cken, 34'h0);
        evt(3'h4);
        repeat (2) @(negedge aclk);
        check({irq, cken}, 34'h3);
        repeat (20) @(posedge aclk);
        rreg(IDX_CORE_CTRL, 4'h0, RESP_OKAY);
        check(irq, 34'h0);
        // four run writes from idle, one zero write while running
        check(34'(nst), 34'd4);
        check(34'(npz), 34'd1);
        give_verdict();
    end
endmodule
